// File: rtl/dmacc_pkg.sv
// constants shared by the dma channel control block and its crc engine
package dmacc_pkg;
  localparam int NCH = 4;
  // register offsets; channel c sits at byte 0x10*(c+1)
  localparam logic [7:0] OFF_CRC_CTRL = 8'h00;
  localparam logic [7:0] OFF_CRC_DATA = 8'h04;
  localparam logic [7:0] OFF_CRC_XOR  = 8'h08;
  localparam logic [3:0] CH_BASE_IDX  = 4'h1;
  localparam logic [3:0] OFF_CON      = 4'h0;
  localparam logic [3:0] OFF_ECON     = 4'h4;
  localparam logic [3:0] OFF_STAT     = 4'h8;
  // crc control fields
  localparam int CRC_POLY_LENGTH_MINUS_ONE_LSB = 8;
  localparam int CRC_EN_BIT   = 7;
  localparam int CRC_KIND_BIT = 5;
  localparam int CRC_CH_LSB   = 0;
  // channel control fields
  localparam int CON_BUSY_BIT  = 15;
  localparam int CON_DIR_BIT   = 8;
  localparam int CON_ON_BIT    = 7;
  localparam int CON_EWO_BIT   = 6;
  localparam int CON_CHAIN_BIT = 5;
  localparam int CON_STAY_BIT  = 4;
  localparam int CON_SEEN_BIT  = 2;
  localparam int CON_PRI_LSB   = 0;
  // channel event control and status fields
  localparam int ECON_ANUM_LSB   = 16;
  localparam int ECON_SNUM_LSB   = 8;
  localparam int ECON_FORCE_BIT  = 7;
  localparam int ECON_FABORT_BIT = 6;
  localparam int ECON_PAT_BIT    = 5;
  localparam int ECON_SEN_BIT    = 4;
  localparam int ECON_AEN_BIT    = 3;
  localparam int STAT_ABORT_BIT  = 0;
  // values after reset
  localparam logic [7:0]  IRQ_NUM_RESET = 8'hFF;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // bits below the polynomial length stay visible
  function automatic logic [31:0] len_mask(input logic [4:0] poly_length_minus_one);
    len_mask = 32'hFFFF_FFFF >> (5'h1F - poly_length_minus_one);
  endfunction
endpackage

// File: rtl/dmacc_crc.sv
// crc generator: shift-register crc with per-stage taps, or ip checksum
`timescale 1ns/1ps
module dmacc_crc
  import dmacc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [31:0] seed,
  input  wire logic        kind,
  input  wire logic [4:0]  poly_length_minus_one,
  input  wire logic [31:0] taps,
  input  wire logic        beat,
  input  wire logic [31:0] data,
  output logic      [31:0] value
);
  typedef struct packed {
    logic [31:0] crc;
  } dmacc_crc_state_t;

  dmacc_crc_state_t s;
  dmacc_crc_state_t next_s;
  logic [31:0]      lfsr;
  logic             fb;
  logic [16:0]      sum;

  always_comb begin
    next_s = s;
    lfsr   = s.crc;
    fb     = 1'b0;
    sum    = 17'h0_0000;
    if (load) begin
      next_s.crc = kind ? {16'h0000, ~seed[15:0]} : seed;
    end else if (beat) begin
      if (kind) begin
        // end-around carry folded after each half-word add
        sum = {1'b0, s.crc[15:0]} + {1'b0, data[31:16]};
        sum = {1'b0, sum[15:0]} + {16'h0000, sum[16]};
        sum = {1'b0, sum[15:0]} + {1'b0, data[15:0]};
        sum = {1'b0, sum[15:0]} + {16'h0000, sum[16]};
        next_s.crc = {16'h0000, sum[15:0]};
      end else begin
        // tap bits 31:1 gate feedback per stage; stage 0 always takes it
        for (int i = 31; i >= 0; i--) begin
          fb   = lfsr[poly_length_minus_one] ^ data[i];
          lfsr = {lfsr[30:0], fb} ^ (taps & {{31{fb}}, 1'b0});
        end
        next_s.crc = lfsr;
      end
    end
  end

  // bits above the length read zero
  // checksum view is low half only
  assign value = kind ? {16'h0000, ~s.crc[15:0]} : (s.crc & len_mask(poly_length_minus_one));

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: rtl/dmacc_top.sv
// dma channel control, event triggers and crc register front end
`timescale 1ns/1ps
module dmacc_top
  import dmacc_pkg::*;
(
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  input  wire logic           PSEL,
  input  wire logic           PENABLE,
  input  wire logic           PWRITE,
  input  wire logic [7:0]     PADDR,
  input  wire logic [31:0]    PWDATA,
  output logic      [31:0]    PRDATA,
  output logic                PREADY,
  output logic                PSLVERR,
  input  wire logic [255:0]   IRQ_LINES,
  input  wire logic [NCH-1:0] PATTERN_HIT,
  input  wire logic           BEAT_ACK,
  input  wire logic [31:0]    BEAT_DATA,
  input  wire logic           BEAT_LAST_CELL,
  input  wire logic           BEAT_LAST_BLOCK,
  output logic                XFER_REQ,
  output logic      [1:0]     XFER_CH
);
  typedef struct packed {
    logic [4:0]            poly_length_minus_one;
    logic                  kind;
    logic                  crc_en;
    logic [2:0]            crc_ch;
    logic [31:0]           taps;
    logic [NCH-1:0]        on;
    logic [NCH-1:0]        dir;
    logic [NCH-1:0]        ewo;
    logic [NCH-1:0]        chain;
    logic [NCH-1:0]        stay;
    logic [NCH-1:0]        seen;
    logic [NCH-1:0]        pat_en;
    logic [NCH-1:0]        sen;
    logic [NCH-1:0]        aen;
    logic [NCH-1:0]        abort_flag;
    logic [NCH-1:0][1:0]   pri;
    logic [NCH-1:0][7:0]   anum;
    logic [NCH-1:0][7:0]   snum;
    logic                  req;
    logic [1:0]            cur;
    logic                  ack;
    logic                  err;
    logic [31:0]           rdata;
  } dmacc_state_t;

  dmacc_state_t   s;
  dmacc_state_t   next_s;
  logic           commit;
  logic           wr;
  logic           top_grp;
  logic           is_ch;
  logic [1:0]     ch_sel;
  logic           hit;
  logic           wr_crc_data;
  logic           crc_beat;
  logic [31:0]    crc_view;
  logic [NCH-1:0] st_ev;
  logic [NCH-1:0] ab_ev;
  logic [NCH-1:0] live;
  logic [NCH-1:0] done_blk;
  logic [NCH+1:0] done_ext;
  logic [NCH-1:0] cand;
  logic [2:0]     pick;

  assign commit  = PSEL & PENABLE & s.ack;
  assign wr      = commit & PWRITE;
  assign top_grp = PADDR[7:4] == 4'h0;
  assign is_ch   = PADDR[7:4] >= CH_BASE_IDX && PADDR[7:4] < CH_BASE_IDX + 4'(NCH);
  assign ch_sel  = 2'(PADDR[7:4] - CH_BASE_IDX);
  assign hit     = PADDR[1:0] == 2'h0 && (top_grp || is_ch) && PADDR[3:0] <= OFF_STAT;
  assign wr_crc_data = wr && PADDR == OFF_CRC_DATA;
  // only the selected channel's beats feed the generator
  assign crc_beat = s.req & BEAT_ACK & s.crc_en & (s.crc_ch == {1'b0, s.cur});

  dmacc_crc u_crc (
    .clk   (CLK_SYS),
    .reset (RESET),
    .load  (wr_crc_data),
    .seed  (PWDATA),
    .kind  (s.kind),
    .poly_length_minus_one  (s.poly_length_minus_one),
    .taps  (s.taps),
    .beat  (crc_beat),
    .data  (BEAT_DATA),
    .value (crc_view)
  );

  // write strobe for one register of channel c
  function automatic logic ch_wr(input int c, input logic [3:0] off);
    ch_wr = wr && is_ch && ch_sel == 2'(c) && PADDR[3:0] == off;
  endfunction

  // highest priority candidate; ties go to the lower channel number
  function automatic logic [2:0] best(input logic [NCH-1:0] m);
    logic       found;
    logic [1:0] idx;
    found = 1'b0;
    idx   = 2'h0;
    for (int c = 0; c < NCH; c++) begin
      if (m[c] && (!found || s.pri[c] > s.pri[idx])) begin
        found = 1'b1;
        idx   = 2'(c);
      end
    end
    best = {found, idx};
  endfunction

  function automatic logic [31:0] rd_word();
    logic [31:0] w;
    logic [1:0]  c;
    w = WORD_RESET;
    c = ch_sel;
    if (top_grp) begin
      case (PADDR[3:0])
        OFF_CRC_CTRL[3:0]: begin
          w[CRC_POLY_LENGTH_MINUS_ONE_LSB +: 5] = s.poly_length_minus_one;
          w[CRC_EN_BIT]        = s.crc_en;
          w[CRC_KIND_BIT]      = s.kind;
          w[CRC_CH_LSB +: 3]   = s.crc_ch;
        end
        OFF_CRC_DATA[3:0]: w = crc_view;
        OFF_CRC_XOR[3:0]:  w = s.taps;
        default:           w = WORD_RESET;
      endcase
    end else begin
      case (PADDR[3:0])
        OFF_CON: begin
          // busy covers enabled or in flight
          w[CON_BUSY_BIT]     = s.on[c] | (s.req & s.cur == c);
          w[CON_DIR_BIT]      = s.dir[c];
          w[CON_ON_BIT]       = s.on[c];
          w[CON_EWO_BIT]      = s.ewo[c];
          w[CON_CHAIN_BIT]    = s.chain[c];
          w[CON_STAY_BIT]     = s.stay[c];
          w[CON_SEEN_BIT]     = s.seen[c];
          w[CON_PRI_LSB +: 2] = s.pri[c];
        end
        OFF_ECON: begin
          // force and abort bits are never stored, so they read zero
          w[ECON_ANUM_LSB +: 8] = s.anum[c];
          w[ECON_SNUM_LSB +: 8] = s.snum[c];
          w[ECON_PAT_BIT]       = s.pat_en[c];
          w[ECON_SEN_BIT]       = s.sen[c];
          w[ECON_AEN_BIT]       = s.aen[c];
        end
        OFF_STAT: w[STAT_ABORT_BIT] = s.abort_flag[c];
        default:  w = WORD_RESET;
      endcase
    end
    rd_word = w;
  endfunction

  always_comb begin
    next_s   = s;
    st_ev    = '0;
    ab_ev    = '0;
    live     = '0;
    done_blk = '0;
    cand     = '0;
    pick     = 3'h0;

    // apb: one wait state, data and error prepared before pready
    next_s.ack   = PSEL & PENABLE & ~s.ack;
    next_s.err   = 1'b0;
    next_s.rdata = WORD_RESET;
    if (PSEL && PENABLE && !s.ack) begin
      next_s.err   = ~hit;
      next_s.rdata = hit && !PWRITE ? rd_word() : WORD_RESET;
    end

    if (wr && PADDR == OFF_CRC_CTRL) begin
      next_s.poly_length_minus_one   = PWDATA[CRC_POLY_LENGTH_MINUS_ONE_LSB +: 5];
      next_s.kind   = PWDATA[CRC_KIND_BIT];
      next_s.crc_en = PWDATA[CRC_EN_BIT];
      next_s.crc_ch = PWDATA[CRC_CH_LSB +: 3];
    end
    if (wr && PADDR == OFF_CRC_XOR) begin
      next_s.taps = PWDATA;
    end

    for (int c = 0; c < NCH; c++) begin
      if (ch_wr(c, OFF_CON)) begin
        next_s.on[c]    = PWDATA[CON_ON_BIT];
        next_s.dir[c]   = PWDATA[CON_DIR_BIT];
        next_s.ewo[c]   = PWDATA[CON_EWO_BIT];
        next_s.chain[c] = PWDATA[CON_CHAIN_BIT];
        next_s.stay[c]  = PWDATA[CON_STAY_BIT];
        next_s.pri[c]   = PWDATA[CON_PRI_LSB +: 2];
      end
      if (ch_wr(c, OFF_ECON)) begin
        next_s.anum[c]   = PWDATA[ECON_ANUM_LSB +: 8];
        next_s.snum[c]   = PWDATA[ECON_SNUM_LSB +: 8];
        next_s.pat_en[c] = PWDATA[ECON_PAT_BIT];
        next_s.sen[c]    = PWDATA[ECON_SEN_BIT];
        next_s.aen[c]    = PWDATA[ECON_AEN_BIT];
      end
      // clear first so a same-cycle abort still sets the flag
      if (ch_wr(c, OFF_STAT) && PWDATA[STAT_ABORT_BIT]) begin
        next_s.abort_flag[c] = 1'b0;
      end
      st_ev[c] = (ch_wr(c, OFF_ECON) & PWDATA[ECON_FORCE_BIT])
               | (s.sen[c] & IRQ_LINES[s.snum[c]]);
      ab_ev[c] = (ch_wr(c, OFF_ECON) & PWDATA[ECON_FABORT_BIT])
               | (s.aen[c] & IRQ_LINES[s.anum[c]])
               | (s.pat_en[c] & PATTERN_HIT[c]);
      live[c]  = s.on[c] | s.ewo[c];
    end

    // in-flight cell finishes even if the channel was disabled
    if (s.req && BEAT_ACK && BEAT_LAST_CELL) begin
      next_s.req = 1'b0;
      if (BEAT_LAST_BLOCK) begin
        done_blk[s.cur] = 1'b1;
        if (!s.stay[s.cur]) begin
          next_s.on[s.cur] = 1'b0;
        end
      end
    end

    // padded so the end channels never index past the vector
    done_ext = {1'b0, done_blk, 1'b0};
    for (int c = 0; c < NCH; c++) begin
      if (s.chain[c]) begin
        if (s.dir[c] && done_ext[c + 2]) begin
          next_s.on[c] = 1'b1;
        end
        if (!s.dir[c] && done_ext[c]) begin
          next_s.on[c] = 1'b1;
        end
      end
    end

    // arbitration by priority field
    // disabled channels with ewo set keep their event but are not granted
    if (!s.req) begin
      cand = s.seen & s.on & ~(ab_ev & live);
      pick = best(cand);
      if (pick[2]) begin
        next_s.req             = 1'b1;
        next_s.cur             = pick[1:0];
        next_s.seen[pick[1:0]] = 1'b0;
      end
    end

    for (int c = 0; c < NCH; c++) begin
      if (live[c]) begin
        if (st_ev[c]) begin
          next_s.seen[c] = 1'b1;
        end
        // abort handled after start, so it wins
        if (ab_ev[c]) begin
          next_s.seen[c]       = 1'b0;
          next_s.abort_flag[c] = 1'b1;
          if (next_s.req && next_s.cur == 2'(c)) begin
            next_s.req = 1'b0;
          end
          if (s.pat_en[c] && PATTERN_HIT[c]) begin
            next_s.on[c] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s      <= '0;
      s.anum <= {NCH{IRQ_NUM_RESET}};
      s.snum <= {NCH{IRQ_NUM_RESET}};
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA   = s.rdata;
  assign PREADY   = s.ack;
  assign PSLVERR  = s.err;
  assign XFER_REQ = s.req;
  assign XFER_CH  = s.cur;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  a_seed_load: assert property (
    wr_crc_data && !s.kind && s.poly_length_minus_one == 5'h1F |=> crc_view == $past(PWDATA))
    else $error("crc seed not loaded");
  a_len_mask: assert property (
    !s.kind |-> (crc_view & ~len_mask(s.poly_length_minus_one)) == 32'h0000_0000)
    else $error("crc bits above length not zero");
  a_ip_upper_zero: assert property (
    s.kind |-> crc_view[31:16] == 16'h0000)
    else $error("checksum upper half not zero");
  a_ip_readback: assert property (
    wr_crc_data && s.kind && !(PSEL && PENABLE && !PWRITE)
      ##1 s.kind && !crc_beat |=> crc_view[15:0] == $past(PWDATA[15:0], 2))
    else $error("checksum readback not written value");
  a_cell_survives: assert property (
    s.req && !BEAT_ACK && (ab_ev & live) == '0 |=> s.req && s.cur == $past(s.cur))
    else $error("in-flight cell dropped without abort");
  a_block_off: assert property (
    s.req && BEAT_ACK && BEAT_LAST_CELL && BEAT_LAST_BLOCK && !s.stay[s.cur]
      && !PSEL |=> !s.on[$past(s.cur)])
    else $error("channel stayed on after block");
  a_seen_set: assert property (
    st_ev[1] && live[1] && !ab_ev[1] |=> s.seen[1] || (s.req && s.cur == 2'h1))
    else $error("start event not recorded");
  a_abort_kill: assert property (
    s.req && ab_ev[s.cur] && live[s.cur] |=> !s.req)
    else $error("abort did not stop transfer");
  a_abort_flag: assert property (
    ab_ev[0] && live[0] |=> s.abort_flag[0])
    else $error("abort flag not set");
  a_no_chain: assert property (
    !s.chain[2] && !s.on[2] && !PSEL |=> !s.on[2])
    else $error("channel enabled without chain allow");
endmodule

// File: verification/dmacc_beat_model.sv
// far-side beat responder for the dma channel control bench
`timescale 1ns/1ps
module dmacc_beat_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req,
  input  wire logic        stall,
  input  wire logic [3:0]  delay,
  input  wire logic        block_end,
  output logic             ack,
  output logic      [31:0] data,
  output logic             last_cell,
  output logic             last_block
);
  logic [3:0] wait_cnt;

  always @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
      data <= 32'h0000_0000;
      last_cell <= 1'b0;
      last_block <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (req && !ack && !stall && wait_cnt >= delay) begin
      ack <= 1'b1;
      data <= $urandom;
      last_cell <= 1'b1;
      last_block <= block_end;
      wait_cnt <= 4'h0;
    end else begin
      // qualifiers mean nothing without ack, so they never hold still
      ack <= 1'b0;
      data <= ~data;
      last_cell <= ~last_cell;
      last_block <= ~last_block;
      wait_cnt <= req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// File: verification/dmacc_top_bench.sv
// self-checking bench for the dma channel control and crc registers
`timescale 1ns/1ps
module dmacc_top_bench;
  import dmacc_pkg::*;
  logic           CLK_SYS, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, XFER_REQ;
  logic           BEAT_ACK, BEAT_LAST_CELL, BEAT_LAST_BLOCK, stall, blk_end, hit, er;
  logic [7:0]     PADDR;
  logic [31:0]    PWDATA, PRDATA, BEAT_DATA, rd, w, t, beat_d;
  logic [1:0]     XFER_CH;
  logic [255:0]   IRQ_LINES;
  logic [NCH-1:0] PATTERN_HIT;
  logic [3:0]     dly;
  logic [4:0]     pl;
  logic [7:0]     n;
  int             failures, num_checks;

  dmacc_top dmacc_top_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ_LINES(IRQ_LINES), .PATTERN_HIT(PATTERN_HIT),
    .BEAT_ACK(BEAT_ACK), .BEAT_DATA(BEAT_DATA), .BEAT_LAST_CELL(BEAT_LAST_CELL),
    .BEAT_LAST_BLOCK(BEAT_LAST_BLOCK), .XFER_REQ(XFER_REQ), .XFER_CH(XFER_CH));
  dmacc_beat_model dmacc_beat_model_i (.clk(CLK_SYS), .reset(RESET), .req(XFER_REQ),
    .stall(stall), .delay(dly), .block_end(blk_end), .ack(BEAT_ACK), .data(BEAT_DATA),
    .last_cell(BEAT_LAST_CELL), .last_block(BEAT_LAST_BLOCK));

  initial CLK_SYS = 1'b0;
  always #25 CLK_SYS = ~CLK_SYS;

  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  // master holds the request until pready is sampled high
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= we;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge so a following call never drives psel twice at once
    @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd, exp, m);
  endtask
  task automatic wait_req(input logic v, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge CLK_SYS);
      hit = (XFER_REQ === v);
    end
  endtask
  task automatic irq(input logic [7:0] k);
    IRQ_LINES[k] <= 1'b1;
    @(posedge CLK_SYS);
    IRQ_LINES <= '0;
  endtask
  function automatic logic [7:0] ca(input int c, input logic [3:0] o);
    ca = 8'((c + 1) * 16) + 8'(o);
  endfunction
  function automatic logic [31:0] lfsr_read(input logic [4:0] p, input logic [31:0] v);
    lfsr_read = v & 32'((33'h1 << (p + 1)) - 33'h1);
  endfunction
  // one granted cell, started by force or by irq k, then the control word afterwards
  task automatic run_cell(input int c, input logic [31:0] con, econ, expc, input int k);
    wr(ca(c, OFF_CON), con);
    wr(ca(c, OFF_ECON), econ);
    if (k >= 0) irq(8'(k));
    wait_req(1'b1, 10);
    chk_bit(hit, 1'b1, "grant");
    chk_word({30'h0, XFER_CH}, 32'(c), "grant channel");
    wait_req(1'b0, 40);
    chk_bit(hit, 1'b1, "cell end");
    rdc(ca(c, OFF_CON), expc, "control after cell");
  endtask
  // enable channel c, force a start and see it granted
  task automatic force_grant(input int c, input logic [31:0] econ);
    wr(ca(c, OFF_CON), 32'h80);
    wr(ca(c, OFF_ECON), econ);
    wait_req(1'b1, 10);
    chk_bit(hit, 1'b1, "forced grant");
  endtask
  // one beat per cell, so the last acked word is the one the crc saw
  always @(posedge CLK_SYS) begin
    if (BEAT_ACK) beat_d <= BEAT_DATA;
  end
  // shift-register crc, msb first, feedback from bit 31, stage 0 always fed
  function automatic logic [31:0] lfsr_run(input logic [31:0] v, tp, d);
    logic [31:0] r;
    logic        f;
    r = v;
    for (int i = 31; i >= 0; i--) begin
      f = r[31] ^ d[i];
      r = {r[30:0], f} ^ ({32{f}} & {tp[31:1], 1'b0});
    end
    lfsr_run = r;
  endfunction
  // ones-complement sum of the stored seed and both halves, read inverted
  function automatic logic [31:0] ip_sum(input logic [31:0] v, d);
    logic [31:0] a;
    a = {16'h0, ~v[15:0]} + {16'h0, d[31:16]} + {16'h0, d[15:0]};
    a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
    a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
    ip_sum = {16'h0, ~a[15:0]};
  endfunction

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    failures++;
    stop_test();
  end

  initial begin
    {RESET, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 43'h0};
    {IRQ_LINES, PATTERN_HIT, stall, blk_end, dly} = '0;
    failures = 0;
    num_checks = 0;
    void'($urandom(32'hd66a0056));
    repeat (10) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    rdc(ca(0, OFF_ECON), 32'h00FF_FF00, "econ reset");
    rdc(ca(3, OFF_CON), WORD_RESET, "control reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk_bit(er, 1'b1, "unmapped");
    apb(1'b0, 8'h12, 32'h0);
    chk_bit(er, 1'b1, "misaligned");
    for (int i = 0; i < 6; i++) begin
      pl = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : 5'($urandom);
      w = $urandom;
      wr(OFF_CRC_CTRL, {19'h0, pl, 8'h00});
      wr(OFF_CRC_DATA, w);
      rdc(OFF_CRC_DATA, lfsr_read(pl, w), "crc seed");
    end
    w = $urandom;
    wr(OFF_CRC_CTRL, 32'h0000_1F20);
    wr(OFF_CRC_DATA, w);
    rdc(OFF_CRC_DATA, {16'h0, w[15:0]}, "checksum read");
    wr(OFF_CRC_XOR, w);
    rdc(OFF_CRC_XOR, w, "taps");
    $display("crc registers done");
    blk_end <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      w = $urandom;
      t = $urandom;
      wr(OFF_CRC_XOR, t);
      wr(OFF_CRC_CTRL, 32'h1F80 | (k << 5));
      wr(OFF_CRC_DATA, w);
      run_cell(0, 32'h80, 32'h00FF_FF80, 32'h0, -1);
      rdc(OFF_CRC_DATA, k ? ip_sum(w, beat_d) : lfsr_run(w, t, beat_d), "crc beat");
    end
    run_cell(0, 32'h80, 32'h00FF_FF80, 32'h0, -1);
    rdc(ca(0, OFF_ECON), 32'h00FF_FF00, "force reads zero");
    run_cell(0, 32'h90, 32'h00FF_FF80, 32'h8090, -1);
    wr(ca(0, OFF_CON), 32'h0);
    for (int c = 0; c < NCH; c++) begin
      n = 8'($urandom);
      dly <= 4'($urandom_range(0, 5));
      run_cell(c, 32'h80 | c, {16'hFF, n, 8'h10}, 32'(c), int'(n));
      wr(ca(c, OFF_ECON), {16'hFF, n, 8'h00});
      wr(ca(c, OFF_CON), 32'h80);
      irq(n);
      wait_req(1'b1, 8);
      chk_bit(hit, 1'b0, "start irq disabled");
    end
    wr(ca(1, OFF_ECON), 32'h00FF_FFC0);
    wait_req(1'b1, 8);
    chk_bit(hit, 1'b0, "abort beats force");
    $display("start tests done");
    for (int d = 0; d < 2; d++) begin
      wr(ca(1, OFF_CON), 32'h0);
      run_cell(d * 2, 32'h80, 32'h00FF_FF80, 32'h0, -1);
      rdc(ca(1, OFF_CON), 32'h0, "no chain");
      wr(ca(1, OFF_CON), 32'h20 | (d << 8));
      run_cell(d * 2, 32'h80, 32'h00FF_FF80, 32'h0, -1);
      rdc(ca(1, OFF_CON), 32'h80A0 | (d << 8), "chained on");
    end
    for (int c = 0; c < NCH; c++) wr(ca(c, OFF_CON), 32'h0);
    $display("chain tests done");
    stall <= 1'b1;
    n = 8'($urandom);
    force_grant(3, {8'h0, n, 16'hFF80});
    // events while off keep the aborts below live once the channel is off
    wr(ca(3, OFF_CON), 32'h40);
    rdc(ca(3, OFF_CON), 32'h8040, "busy while draining");
    irq(n);
    wait_req(1'b0, 5);
    chk_bit(hit, 1'b0, "abort irq disabled");
    wr(ca(3, OFF_ECON), {8'h0, n, 16'hFF40});
    wait_req(1'b0, 5);
    chk_bit(hit, 1'b1, "force abort");
    rdc(ca(3, OFF_ECON), {8'h0, n, 16'hFF00}, "abort reads zero");
    wr(ca(3, OFF_STAT), 32'h1);
    force_grant(3, {8'h0, n, 16'hFF88});
    irq(n);
    wait_req(1'b0, 5);
    chk_bit(hit, 1'b1, "irq abort");
    rdc(ca(3, OFF_STAT), 32'h1, "abort flag");
    wr(ca(3, OFF_STAT), 32'h1);
    rdc(ca(3, OFF_STAT), 32'h0, "abort flag clear");
    force_grant(3, 32'h00FF_FFA0);
    PATTERN_HIT[3] <= 1'b1;
    @(posedge CLK_SYS);
    PATTERN_HIT <= '0;
    wait_req(1'b0, 5);
    chk_bit(hit, 1'b1, "pattern abort");
    rdc(ca(3, OFF_CON), 32'h0, "pattern clears on");
    $display("abort tests done");
    wr(ca(2, OFF_ECON), 32'h00FF_FF80);
    rdc(ca(2, OFF_CON), 32'h0, "event ignored while off");
    wr(ca(2, OFF_CON), 32'h40);
    wr(ca(2, OFF_ECON), 32'h00FF_FF80);
    rdc(ca(2, OFF_CON), 32'h44, "event kept while off");
    force_grant(0, 32'h00FF_FF80);
    rdc(ca(0, OFF_CON), 32'h8080, "busy in flight");
    wr(ca(1, OFF_CON), 32'h81);
    wr(ca(1, OFF_ECON), 32'h00FF_FF80);
    wr(ca(2, OFF_CON), 32'hC3);
    stall <= 1'b0;
    wait_req(1'b0, 20);
    wait_req(1'b1, 10);
    chk_word({30'h0, XFER_CH}, 32'h2, "highest priority first");
    wait_req(1'b0, 20);
    wait_req(1'b1, 10);
    chk_word({30'h0, XFER_CH}, 32'h1, "lower priority next");
    $display("priority tests done");
    stop_test();
  end
endmodule
